/* File: ccd_readout_pkg.sv */
/*
 Constants, types and timing counts shared by the sensor end and the
 timing-generator end of the frame-transfer sensor readout link.
 Assumes a single 125 MHz clock on both ends.
*/
package ccd_readout_pkg;

  // Clock and gate-drive rates, in kHz; clear time in us
  localparam int CLK_KHZ = 125000;
  localparam int SERIAL_MAX_KHZ = 4770;
  localparam int PARALLEL_MAX_KHZ = 3580;
  localparam int BLOOM_KHZ = 2000;
  localparam int CLEAR_US = 10;

  // Derived cycle counts; least periods round up
  localparam int SERIAL_CYC = (CLK_KHZ + SERIAL_MAX_KHZ - 1) / SERIAL_MAX_KHZ;
  localparam int PHASE_CYC = (SERIAL_CYC + 2) / 3;
  localparam int FRAME_CYC = (CLK_KHZ + PARALLEL_MAX_KHZ - 1) / PARALLEL_MAX_KHZ;
  localparam int BLOOM_HALF_CYC = ((CLK_KHZ + BLOOM_KHZ - 1) / BLOOM_KHZ + 1) / 2;
  localparam int CLEAR_CYC = CLEAR_US * CLK_KHZ / 1000;

  // Array geometry
  localparam int IMAGE_LINES = 242;
  localparam int SHIELD_LINES = 2;
  localparam int SHIFT_LINES = IMAGE_LINES + SHIELD_LINES;
  localparam int LINE_ELEMS = 786;
  localparam int LEFT_DARK_COLS = 2;
  localparam int ACTIVE_COLS = 755;
  localparam int RIGHT_DARK_COLS = 29;
  localparam int OUTPUTS = 3;
  localparam int COLS_PER_OUT = LINE_ELEMS / OUTPUTS;
  localparam int DUMMY_ELEMS = 11;
  localparam int SERIAL_STEPS = COLS_PER_OUT + DUMMY_ELEMS;

  // Blanking sequence
  localparam int BLOOM_BURST = 4;
  localparam int XFER_STEP = 2 * BLOOM_BURST;
  localparam int BLANK_STEPS = XFER_STEP + 2;

  // Video levels
  localparam int PIXEL_W = 10;
  localparam int SCENE_W = PIXEL_W - 1;
  localparam int DARK_LEVEL = 16;
  localparam int INTERLACE_DARK = 8;

  // Field widths
  localparam int LINE_W = 8;
  localparam int COL_W = 10;
  localparam int STEP_W = 9;
  localparam int CNT_W = 16;

  typedef logic [OUTPUTS-1:0][PIXEL_W-1:0] triplet_t;

  // One serial step: three columns of one line
  typedef struct packed {
    logic last;
    logic [LINE_W-1:0] line;
    triplet_t px;
  } sample_s;

  typedef enum logic [1:0] {
    ST_CLEAR = 2'h0,
    ST_SHIFT = 2'h1,
    ST_BLANK = 2'h3,
    ST_READ = 2'h2
  } gen_state_e;

endpackage

/* File: ccd_link_if.sv */
/*
 Gate drives from the timing generator to the sensor, and the video
 samples with valid and ready back. Both ends on the same clock.
*/
`timescale 1ns/100ps
interface ccd_link_if;
  import ccd_readout_pkg::*;

  logic antiblooming_gate_drive;
  logic image_area_gate_drive;
  logic storage_area_gate_drive;
  logic line_transfer_gate_drive;
  logic serial_register_gate_1;
  logic serial_register_gate_2;
  logic serial_register_gate_3;
  logic clearing_drain_bias;
  logic interlace_drive;
  logic field_odd;
  sample_s video;
  logic video_valid;
  logic video_ready;

  modport sensor_end (
    input antiblooming_gate_drive, image_area_gate_drive, storage_area_gate_drive,
    input line_transfer_gate_drive, serial_register_gate_1, serial_register_gate_2,
    input serial_register_gate_3, clearing_drain_bias, interlace_drive, field_odd,
    input video_ready,
    output video, video_valid
  );

  modport generator_end (
    output antiblooming_gate_drive, image_area_gate_drive, storage_area_gate_drive,
    output line_transfer_gate_drive, serial_register_gate_1, serial_register_gate_2,
    output serial_register_gate_3, clearing_drain_bias, interlace_drive, field_odd,
    output video_ready,
    input video, video_valid
  );
endinterface // ccd_link_if

/* File: ccd_timing_gen.sv */
/*
 Timing-generator end: sequences clear, frame shift, blanking with
 antiblooming bursts and line transfer, then serial readout, and hands
 the received video to the user side through a one-entry output stage.
 Assumes the sensor end on the same clock through ccd_link_if.
*/
`timescale 1ns/100ps
module ccd_timing_gen
  import ccd_readout_pkg::*;
#(
  // Lines read per field
  parameter int FIELD_LINES = IMAGE_LINES
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Link
  ccd_link_if.generator_end link,
  // User control
  input wire logic interlace_mode,
  input wire logic clear_request,
  // User video
  output sample_s pixel,
  output logic pixel_valid,
  input wire logic pixel_ready
);

  gen_state_e state_reg;
  logic [CNT_W-1:0] tmr_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [1:0] ph_reg;
  logic [LINE_W-1:0] line_reg;
  logic field_reg;
  logic take;
  logic out_valid_next;
  logic step_end;

  // Shift pulses per field: image lines plus the shielded ones
  localparam int FIELD_SHIFTS = FIELD_LINES + SHIELD_LINES;

  assign take = link.video_valid & link.video_ready;
  assign out_valid_next = (pixel_valid & ~pixel_ready) | take;

  ////////////////////////////////////////////////////////////////////////////
  // Timer end of the current step, per state
  always_comb begin
    case (state_reg)
      ST_CLEAR: step_end = (tmr_reg == CNT_W'(CLEAR_CYC - 1));
      ST_SHIFT: step_end = (tmr_reg == CNT_W'(FRAME_CYC - 1));
      ST_BLANK: step_end = (tmr_reg == CNT_W'(BLOOM_HALF_CYC - 1));
      default: step_end = (tmr_reg == CNT_W'(PHASE_CYC - 1));
    endcase
  end

  // Sequencer: clear, then one field per shift
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= ST_CLEAR;
      tmr_reg <= '0;
      cnt_reg <= '0;
      ph_reg <= '0;
      line_reg <= '0;
      field_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_CLEAR: begin
          tmr_reg <= step_end ? '0 : tmr_reg + 1'b1;
          if (step_end) begin
            state_reg <= ST_BLANK;
            cnt_reg <= '0;
            line_reg <= '0;
          end
        end
        ST_SHIFT: begin
          tmr_reg <= step_end ? '0 : tmr_reg + 1'b1;
          if (step_end) begin
            cnt_reg <= cnt_reg + 1'b1;
            if (cnt_reg == CNT_W'(FIELD_SHIFTS - 1)) begin
              state_reg <= ST_BLANK;
              cnt_reg <= '0;
              line_reg <= '0;
              field_reg <= interlace_mode & ~field_reg;
            end
          end
        end
        ST_BLANK: begin
          if (cnt_reg == '0 && tmr_reg == '0 && clear_request) begin
            state_reg <= ST_CLEAR;
          end else begin
            tmr_reg <= step_end ? '0 : tmr_reg + 1'b1;
            if (step_end) begin
              cnt_reg <= cnt_reg + 1'b1;
              if (cnt_reg == CNT_W'(BLANK_STEPS - 1)) begin
                state_reg <= ST_READ;
                cnt_reg <= '0;
                ph_reg <= '0;
              end
            end
          end
        end
        default: begin
          // Stall between steps while video_ready is low
          if (!(ph_reg == 2'h0 && tmr_reg == '0 && !link.video_ready)) begin
            tmr_reg <= step_end ? '0 : tmr_reg + 1'b1;
            if (step_end) begin
              ph_reg <= (ph_reg == 2'h2) ? 2'h0 : ph_reg + 1'b1;
              if (ph_reg == 2'h2) begin
                cnt_reg <= cnt_reg + 1'b1;
                if (cnt_reg == CNT_W'(SERIAL_STEPS - 1)) begin
                  cnt_reg <= '0;
                  line_reg <= line_reg + 1'b1;
                  state_reg <= (line_reg == LINE_W'(FIELD_LINES - 1)) ? ST_SHIFT : ST_BLANK;
                end
              end
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered gate drives
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      link.clearing_drain_bias <= 1'b1;
      link.image_area_gate_drive <= 1'b0;
      link.storage_area_gate_drive <= 1'b0;
      link.antiblooming_gate_drive <= 1'b0;
      link.line_transfer_gate_drive <= 1'b0;
      link.serial_register_gate_1 <= 1'b0;
      link.serial_register_gate_2 <= 1'b0;
      link.serial_register_gate_3 <= 1'b0;
      link.interlace_drive <= 1'b0;
      link.field_odd <= 1'b0;
    end else begin
      link.clearing_drain_bias <= (state_reg == ST_CLEAR);
      link.image_area_gate_drive <= (state_reg == ST_SHIFT) && (tmr_reg < CNT_W'(FRAME_CYC / 2));
      link.storage_area_gate_drive <= (state_reg == ST_SHIFT) && (tmr_reg < CNT_W'(FRAME_CYC / 2));
      link.antiblooming_gate_drive <= (state_reg == ST_BLANK) && (cnt_reg < CNT_W'(XFER_STEP)) && cnt_reg[0];
      link.line_transfer_gate_drive <= (state_reg == ST_BLANK) && (cnt_reg == CNT_W'(XFER_STEP));
      link.serial_register_gate_1 <= ((state_reg == ST_BLANK) && (cnt_reg == CNT_W'(XFER_STEP)))
                                     || ((state_reg == ST_READ) && (ph_reg == 2'h0) && (tmr_reg != '0));
      link.serial_register_gate_2 <= ((state_reg == ST_BLANK) && (cnt_reg == CNT_W'(XFER_STEP)))
                                     || ((state_reg == ST_READ) && (ph_reg == 2'h1));
      link.serial_register_gate_3 <= ((state_reg == ST_BLANK) && (cnt_reg == CNT_W'(XFER_STEP)))
                                     || ((state_reg == ST_READ) && (ph_reg == 2'h2));
      link.interlace_drive <= interlace_mode;
      link.field_odd <= field_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage; ready is registered, so at most one word in flight
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pixel <= '0;
      pixel_valid <= 1'b0;
      link.video_ready <= 1'b0;
    end else begin
      if (take) begin
        pixel <= link.video;
      end
      pixel_valid <= out_valid_next;
      link.video_ready <= ~out_valid_next & ~link.video_ready;
    end
  end

endmodule // ccd_timing_gen

/* File: ccd_sensor_end.sv */
/*
 Sensor end: a digital stand-in for the frame-transfer sensor. It
 follows the gate drives, keeps frame and line state, clocks the serial
 registers through their dummy elements and emits three interleaved
 columns per serial step through a two-entry buffer.
 Assumes the timing generator on the same clock through ccd_link_if.
*/
// Function
// - Generator bursts antiblooming pulses every blanking interval
// - After integration whole frame shifts into storage
// - Line transfer pulses only during horizontal blanking
// - Stored lines move one at a time
// - Three outputs, each every third column
// - 242 lines of 786 elements each
// - Right edge: 29.5 shielded dark columns (modelled as 29)
// - Left 1.5 columns, two shielded lines dark (modelled as 2 dark columns)
// - Interlace shifts alternate fields half line
// - Noninterlaced mode gives lower dark signal
// - Reset and clamp, transfer, then sample
// - Serial phases two, three time reset, sample
// - Eleven dummy elements clocked before real pixels
// - Clearing drain empties sensing and storage areas
`timescale 1ns/100ps
module ccd_sensor_end
  import ccd_readout_pkg::*;
#(
  // Lines stored per field
  parameter int FIELD_LINES = IMAGE_LINES
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Link
  ccd_link_if.sensor_end link,
  // Scene
  input wire logic [SCENE_W-1:0] scene_level,
  // Status
  output logic frame_stored,
  output logic antibloom_seen
);

  // Shift pulses per field: image lines plus the shielded ones
  localparam int FIELD_SHIFTS = FIELD_LINES + SHIELD_LINES;

  logic image_gate_prev_reg;
  logic xfer_gate_prev_reg;
  logic phase2_prev_reg;
  logic phase3_prev_reg;
  logic bloom_prev_reg;
  logic shift_pulse;
  logic xfer_pulse;
  logic phase2_pulse;
  logic phase3_pulse;
  logic [LINE_W-1:0] shift_cnt_reg;
  logic [SCENE_W-1:0] stored_scene_reg;
  logic stored_field_reg;
  logic stored_ilace_reg;
  logic [LINE_W-1:0] line_idx_reg;
  logic [LINE_W-1:0] ser_line_reg;
  logic ser_loaded_reg;
  logic [STEP_W-1:0] ser_step_reg;
  logic node_reset_reg;
  logic push_reg;
  sample_s push_data_reg;
  sample_s tail_reg;
  logic tail_valid_reg;
  logic pop;
  logic [STEP_W-1:0] col_step;
  triplet_t px_next;

  ////////////////////////////////////////////////////////////////////////////
  // Value of one element: dark where shielded, scene where lit
  function automatic logic [PIXEL_W-1:0] pixel_value(
    input logic [COL_W-1:0] col,
    input logic [LINE_W-1:0] line,
    input logic field,
    input logic ilace,
    input logic [SCENE_W-1:0] scene
  );
    logic [PIXEL_W-1:0] dark;
    logic [PIXEL_W-1:0] vpos;
    dark = ilace ? PIXEL_W'(DARK_LEVEL + INTERLACE_DARK) : PIXEL_W'(DARK_LEVEL);
    vpos = PIXEL_W'({line[1:0], field & ilace});
    if (col < COL_W'(LEFT_DARK_COLS)) begin
      pixel_value = dark;
    end else if (col >= COL_W'(LEFT_DARK_COLS + ACTIVE_COLS)) begin
      pixel_value = dark;
    end else begin
      pixel_value = dark + PIXEL_W'(scene) + vpos;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Edge detect on gate drives; both ends share the clock
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      image_gate_prev_reg <= 1'b0;
      xfer_gate_prev_reg <= 1'b0;
      phase2_prev_reg <= 1'b0;
      phase3_prev_reg <= 1'b0;
      bloom_prev_reg <= 1'b0;
    end else begin
      image_gate_prev_reg <= link.image_area_gate_drive;
      xfer_gate_prev_reg <= link.line_transfer_gate_drive;
      phase2_prev_reg <= link.serial_register_gate_2;
      phase3_prev_reg <= link.serial_register_gate_3;
      bloom_prev_reg <= link.antiblooming_gate_drive;
    end
  end

  // A frame shift needs both area gates together
  assign shift_pulse = link.image_area_gate_drive & ~image_gate_prev_reg & link.storage_area_gate_drive;
  assign xfer_pulse = link.line_transfer_gate_drive & ~xfer_gate_prev_reg;
  assign phase2_pulse = link.serial_register_gate_2 & ~phase2_prev_reg;
  assign phase3_pulse = link.serial_register_gate_3 & ~phase3_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame shift into storage and clearing
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      shift_cnt_reg <= '0;
      frame_stored <= 1'b0;
      stored_scene_reg <= '0;
      stored_field_reg <= 1'b0;
      stored_ilace_reg <= 1'b0;
    end else if (link.clearing_drain_bias) begin
      shift_cnt_reg <= '0;
      frame_stored <= 1'b0;
    end else if (shift_pulse) begin
      // 244 rows: image plus shielded lines
      if (shift_cnt_reg == LINE_W'(FIELD_SHIFTS - 1)) begin
        shift_cnt_reg <= '0;
        frame_stored <= 1'b1;
        stored_scene_reg <= scene_level;
        stored_field_reg <= link.field_odd;
        stored_ilace_reg <= link.interlace_drive;
      end else begin
        shift_cnt_reg <= shift_cnt_reg + 1'b1;
        frame_stored <= 1'b0;
      end
    end
  end

  // Antiblooming activity since the last completed shift
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      antibloom_seen <= 1'b0;
    end else if (link.antiblooming_gate_drive & ~bloom_prev_reg) begin
      antibloom_seen <= 1'b1;
    end else if (shift_pulse && shift_cnt_reg == LINE_W'(FIELD_SHIFTS - 1)) begin
      antibloom_seen <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line transfer into the serial registers and serial stepping
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      line_idx_reg <= '0;
      ser_line_reg <= '0;
      ser_loaded_reg <= 1'b0;
      ser_step_reg <= '0;
    end else if (link.clearing_drain_bias || (shift_pulse && shift_cnt_reg == LINE_W'(FIELD_SHIFTS - 1))) begin
      line_idx_reg <= '0;
      ser_loaded_reg <= 1'b0;
    end else if (xfer_pulse) begin
      ser_step_reg <= '0;
      ser_line_reg <= line_idx_reg;
      // no more than 242 lines per field
      if (frame_stored && line_idx_reg < LINE_W'(FIELD_LINES)) begin
        ser_loaded_reg <= 1'b1;
        line_idx_reg <= line_idx_reg + 1'b1;
      end else begin
        ser_loaded_reg <= 1'b0;
      end
    end else if (phase3_pulse && node_reset_reg && ser_loaded_reg) begin
      ser_step_reg <= ser_step_reg + 1'b1;
      if (ser_step_reg == STEP_W'(SERIAL_STEPS - 1)) begin
        ser_loaded_reg <= 1'b0;
      end
    end
  end

  // Output node: reset and clamp on phase two, sample on phase three
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      node_reset_reg <= 1'b0;
    end else if (phase2_pulse) begin
      node_reset_reg <= 1'b1;
    end else if (phase3_pulse || xfer_pulse) begin
      node_reset_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Three columns of one step, interleaved across the outputs
  assign col_step = ser_step_reg - STEP_W'(DUMMY_ELEMS);
  always_comb begin
    for (int k = 0; k < OUTPUTS; k++) begin
      px_next[k] = pixel_value(COL_W'(col_step) * COL_W'(OUTPUTS) + COL_W'(k),
                               ser_line_reg, stored_field_reg, stored_ilace_reg, stored_scene_reg);
    end
  end

  // Sample on phase three once the node was reset
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      push_reg <= 1'b0;
      push_data_reg <= '0;
    end else begin
      // sample only after reset and clamp
      push_reg <= phase3_pulse && node_reset_reg && ser_loaded_reg && (ser_step_reg >= STEP_W'(DUMMY_ELEMS));
      if (phase3_pulse) begin
        push_data_reg.px <= px_next;
        push_data_reg.line <= ser_line_reg;
        push_data_reg.last <= (ser_step_reg == STEP_W'(SERIAL_STEPS - 1));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer: head drives the link, tail absorbs a stall
  assign pop = link.video_valid & link.video_ready;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      link.video <= '0;
      link.video_valid <= 1'b0;
      tail_reg <= '0;
      tail_valid_reg <= 1'b0;
    end else begin
      if (!link.video_valid || pop) begin
        // Head refills from tail first to keep order
        if (tail_valid_reg) begin
          link.video <= tail_reg;
          link.video_valid <= 1'b1;
          tail_reg <= push_data_reg;
          tail_valid_reg <= push_reg;
        end else begin
          link.video <= push_data_reg;
          link.video_valid <= push_reg;
        end
      end else if (push_reg && !tail_valid_reg) begin
        tail_reg <= push_data_reg;
        tail_valid_reg <= 1'b1;
      end
    end
  end

endmodule // ccd_sensor_end

/* File: ccd_link_chk.sv */
/*
 Checker for the sensor link: gate drive shapes and the video handshake.
 Assumes plain inputs wired by name to ccd_link_if, one clock domain.
*/
`timescale 1ns/100ps
module ccd_link_chk
  import ccd_readout_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Gate drives
  input wire logic antiblooming_gate_drive,
  input wire logic image_area_gate_drive,
  input wire logic storage_area_gate_drive,
  input wire logic line_transfer_gate_drive,
  input wire logic serial_register_gate_1,
  input wire logic serial_register_gate_2,
  input wire logic serial_register_gate_3,
  input wire logic clearing_drain_bias,
  // Video
  input wire sample_s video,
  input wire logic video_valid,
  input wire logic video_ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////
  // Node reset on phase two, sample on phase three nine cycles on
  sequence node_reset;
    $rose(serial_register_gate_2) && !serial_register_gate_3;
  endsequence
  sequence node_sample;
    ##9 $rose(serial_register_gate_3);
  endsequence

  ////////////////////////////////////////////////////////////////////////
  a_reset_gates_idle: assert property ($rose(reset_n) |-> clearing_drain_bias && !line_transfer_gate_drive
    && !antiblooming_gate_drive && !video_valid) else $error("gates not idle after reset");
  a_clear_gates_quiet: assert property (clearing_drain_bias |-> !line_transfer_gate_drive
    && !image_area_gate_drive && !antiblooming_gate_drive) else $error("gate pulsed during clear");
  a_frame_gates_paired: assert property (image_area_gate_drive == storage_area_gate_drive)
    else $error("image and storage gates differ");
  a_transfer_width: assert property ($rose(line_transfer_gate_drive) |->
    ##31 line_transfer_gate_drive ##1 !line_transfer_gate_drive) else $error("transfer pulse width wrong");
  a_transfer_with_serial: assert property (line_transfer_gate_drive |-> serial_register_gate_1
    && serial_register_gate_2 && serial_register_gate_3) else $error("serial gates low in transfer");
  a_bloom_pulse: assert property ($rose(antiblooming_gate_drive) |->
    ##31 antiblooming_gate_drive ##1 !antiblooming_gate_drive[*8]) else $error("bloom pulse shape wrong");
  a_reset_then_sample: assert property (node_reset |-> node_sample)
    else $error("sample phase not nine cycles after reset phase");
  a_video_stands: assert property (video_valid && !video_ready |=> video_valid && $stable(video))
    else $error("video dropped before taken");
  a_ready_gap: assert property (video_valid && video_ready |=> !video_ready)
    else $error("ready not lowered after take");
endmodule // ccd_link_chk

/* File: testbench.sv */
/*
 Testbench joining both link ends; checks clear, blanking and line readout.
 Assumes the package, interface and both ends compiled before it.
*/
`timescale 1ns/100ps
module testbench;
  import ccd_readout_pkg::*;

  logic clock;
  logic reset_n;
  logic interlace_mode;
  logic clear_request;
  logic pixel_ready;
  logic [SCENE_W-1:0] scene_level;
  sample_s pixel;
  logic pixel_valid;
  logic frame_stored;
  logic antibloom_seen;
  int num_errors;
  int num_checks;

  // Short field: a full 242-line field would far outrun the run budget
  localparam int TB_LINES = 2;

  ccd_link_if link ();
  ccd_timing_gen #(.FIELD_LINES(TB_LINES)) ccd_timing_gen_i (.clock(clock), .reset_n(reset_n), .link(link),
    .interlace_mode(interlace_mode), .clear_request(clear_request), .pixel(pixel),
    .pixel_valid(pixel_valid), .pixel_ready(pixel_ready));
  ccd_sensor_end #(.FIELD_LINES(TB_LINES)) ccd_sensor_end_i (.clock(clock), .reset_n(reset_n), .link(link),
    .scene_level(scene_level), .frame_stored(frame_stored), .antibloom_seen(antibloom_seen));
  ccd_link_chk ccd_link_chk_i (.clock(clock), .reset_n(reset_n),
    .antiblooming_gate_drive(link.antiblooming_gate_drive), .image_area_gate_drive(link.image_area_gate_drive),
    .storage_area_gate_drive(link.storage_area_gate_drive),
    .line_transfer_gate_drive(link.line_transfer_gate_drive),
    .serial_register_gate_1(link.serial_register_gate_1), .serial_register_gate_2(link.serial_register_gate_2),
    .serial_register_gate_3(link.serial_register_gate_3), .clearing_drain_bias(link.clearing_drain_bias),
    .video(link.video), .video_valid(link.video_valid), .video_ready(link.video_ready));

  // Free-running clock, 8 ns period
  always #4 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask

  task tick;
    @(negedge clock);
  endtask

  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Clear phase length; one cycle of slack for the release edge
  task automatic clear_time;
    int n;
    n = 0;
    while (link.clearing_drain_bias === 1'b1 && n < 3000) begin
      tick;
      n++;
    end
    check("clear length in range", 1, n >= CLEAR_CYC && n <= CLEAR_CYC + 1);
  endtask

  // Counts bloom and serial rises up to the next transfer pulse
  task automatic scan(output int bloom_n, output int ser_n, output int vid_n);
    logic pb;
    logic ps;
    int n;
    bloom_n = 0;
    ser_n = 0;
    vid_n = 0;
    n = 0;
    pb = link.antiblooming_gate_drive;
    ps = link.serial_register_gate_3;
    while (link.line_transfer_gate_drive !== 1'b1 && n < 20000) begin
      tick;
      n++;
      if (link.antiblooming_gate_drive && !pb) bloom_n++;
      if (link.serial_register_gate_3 && !ps && !link.line_transfer_gate_drive) ser_n++;
      if (link.video_valid !== 1'b0) vid_n++;
      pb = link.antiblooming_gate_drive;
      ps = link.serial_register_gate_3;
    end
  endtask

  // Transfer pulse length, serial gates held high all through
  task automatic transfer_width;
    int n;
    int bad;
    n = 0;
    bad = 0;
    while (link.line_transfer_gate_drive === 1'b1 && n < 100) begin
      if (!(link.serial_register_gate_1 && link.serial_register_gate_2 && link.serial_register_gate_3)) bad++;
      tick;
      n++;
    end
    check("transfer high cycles", BLOOM_HALF_CYC, n);
    check("serial low in transfer", 0, bad);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task t_reset_clear;
    check("video valid after reset", 0, link.video_valid);
    check("bloom seen after reset", 0, antibloom_seen);
    clear_time();
  endtask

  task automatic t_blank_burst;
    int b, s, v;
    scan(b, s, v);
    check("bloom pulses per blanking", BLOOM_BURST, b);
    check("serial steps before first line", 0, s);
    transfer_width();
    check("bloom seen flag", 1, antibloom_seen);
  endtask

  // First field after clear reads empty storage, so no video appears
  task automatic t_line_read;
    int b, s, v;
    scan(b, s, v);
    check("serial steps per line", SERIAL_STEPS, s);
    check("bloom pulses next blanking", BLOOM_BURST, b);
    check("video words from empty storage", 0, v);
    check("frame stored", 0, frame_stored);
    check("pixel valid", 0, pixel_valid);
    transfer_width();
  endtask

  task t_interlace;
    interlace_mode = 1'b1;
    repeat (2) tick;
    check("interlace drive on", 1, link.interlace_drive);
    check("field parity before shift", 0, link.field_odd);
    interlace_mode = 1'b0;
    repeat (2) tick;
    check("interlace drive off", 0, link.interlace_drive);
  endtask

  // After the shift the stored frame reads out: one line of interleaved words
  task automatic t_video;
    int n;
    int words;
    sample_s first_word;
    sample_s last_word;
    n = 0;
    words = 0;
    first_word = '0;
    last_word = '0;
    while (words < COLS_PER_OUT && n < 20000) begin
      tick;
      n++;
      if (pixel_valid === 1'b1) begin
        if (words == 0) first_word = pixel;
        last_word = pixel;
        words++;
      end
    end
    check("frame stored", 1, frame_stored);
    check("words per line", COLS_PER_OUT, words);
    check("left shielded column 0", DARK_LEVEL, first_word.px[0]);
    check("left shielded column 1", DARK_LEVEL, first_word.px[1]);
    check("first lit column", DARK_LEVEL + scene_level, first_word.px[2]);
    check("first word line", 0, first_word.line);
    check("first word last flag", 0, first_word.last);
    check("last word last flag", 1, last_word.last);
    check("right dark column", DARK_LEVEL, last_word.px[2]);
  endtask

  // Request is only taken at the start of a blanking interval
  task automatic t_clear_request;
    int n, b, s, v;
    n = 0;
    clear_request = 1'b1;
    while (link.clearing_drain_bias !== 1'b1 && n < 20000) begin
      tick;
      n++;
    end
    clear_request = 1'b0;
    check("clear on request", 1, link.clearing_drain_bias);
    clear_time();
    scan(b, s, v);
    check("bloom pulses after clear", BLOOM_BURST, b);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    interlace_mode = 1'b0;
    clear_request = 1'b0;
    pixel_ready = 1'b1;
    scene_level = 9'h0A5;
    num_errors = 0;
    num_checks = 0;
    repeat (2) tick;
    reset_n = 1'b1;
    t_reset_clear();
    t_blank_burst();
    t_line_read();
    t_interlace();
    t_video();
    t_clear_request();
    report_and_stop();
  end

  // Watchdog: the sequence needs about 27000 cycles
  initial begin
    repeat (90000) @(posedge clock);
    num_errors++;
    report_and_stop();
  end
endmodule // testbench
